//--- rtl/iuvp_map.vh
// constants for the integer-unit variant profile
`ifndef IUVP_MAP_VH
`define IUVP_MAP_VH
// variant selection codes
`define IUVP_VAR_A            3'h0
`define IUVP_VAR_B0           3'h1
`define IUVP_VAR_B1           3'h2
`define IUVP_VAR_C            3'h3
`define IUVP_VAR_D            3'h4
// instruction class codes
`define IUVP_CLS_OTHER        5'h00
`define IUVP_CLS_LD_SINGLE    5'h01
`define IUVP_CLS_LD_DOUBLE    5'h02
`define IUVP_CLS_ST_SINGLE    5'h03
`define IUVP_CLS_ST_DOUBLE    5'h04
`define IUVP_CLS_BR_UNTAKEN   5'h05
`define IUVP_CLS_BR_TAKEN     5'h06
`define IUVP_CLS_TRAP_TAKEN   5'h07
`define IUVP_CLS_TRAP_UNTAKEN 5'h08
`define IUVP_CLS_JUMP_LINK    5'h09
`define IUVP_CLS_RET_TRAP     5'h0A
`define IUVP_CLS_ATOMIC_LDST  5'h0B
`define IUVP_CLS_SWAP         5'h0C
`define IUVP_CLS_STORE_FQ     5'h0D
`define IUVP_CLS_UNSIGNED_MULTIPLY         5'h0E
`define IUVP_CLS_UNSIGNED_MULTIPLY_FLAGS   5'h0F
`define IUVP_CLS_SIGNED_MULTIPLY         5'h10
`define IUVP_CLS_SIGNED_MULTIPLY_FLAGS   5'h11
`define IUVP_CLS_STORE_BAR    5'h12
`define IUVP_CLS_WRITE_ANC    5'h13
`define IUVP_CLS_WRITE_Y      5'h14
`define IUVP_CLS_READ_Y       5'h15
// cycle counts
`define IUVP_CYC_1            3'h1
`define IUVP_CYC_2            3'h2
`define IUVP_CYC_3            3'h3
`define IUVP_CYC_4            3'h4
`define IUVP_CYC_5            3'h5
// trap type codes
`define IUVP_TT_RESET         8'h00
`define IUVP_TT_ILLEGAL       8'h02
`define IUVP_TT_PRIVILEGED    8'h03
`define IUVP_TT_INSTR_MISS    8'h3C
`define IUVP_TT_DATA_MISS     8'h2C
`define IUVP_TT_INSTR_ERR     8'h21
`define IUVP_TT_REG_ERR       8'h20
`define IUVP_TT_DATA_ERR      8'h29
`define IUVP_TT_WATCHPOINT    8'h0B
`define IUVP_TT_ERROR_RESET   8'h20
// trap request bit positions
`define IUVP_TRQ_ERROR_MODE   0
`define IUVP_TRQ_INSTR_MISS   1
`define IUVP_TRQ_INSTR_ERR    2
`define IUVP_TRQ_PRIVILEGED   3
`define IUVP_TRQ_ILLEGAL      4
`define IUVP_TRQ_REG_ERR      5
`define IUVP_TRQ_DATA_ERR     6
`define IUVP_TRQ_DATA_MISS    7
`define IUVP_TRQ_WATCHPOINT   8
`define IUVP_TRQ_W            9
// address widths
`define IUVP_ADDR_MASK_B1     32'h00FFFFFF
`define IUVP_ADDR_MASK_FULL   32'hFFFFFFFF
`define IUVP_ASI_MASK_B1      8'h07
`define IUVP_ASI_MASK_D       8'h7F
`define IUVP_ASI_MASK_FULL    8'hFF
// register windows
`define IUVP_WIN_SEVEN        4'h7
`define IUVP_WIN_EIGHT        4'h8
// reset values
`define IUVP_RST_TT           8'h00
`define IUVP_RST_CNT          3'h0
`endif

//--- rtl/iuvp_cycle_table.v
// cycle count lookup per instruction class and variant
`include "iuvp_map.vh"
module iuvp_cycle_table #(
   parameter [2:0] VARIANT = `IUVP_VAR_A
) (
   input  wire [4:0] cls_i,
   input  wire       reg_reg_addr_i,
   output reg  [2:0] cycles_o
);
   // one lookup shared by A/B0/B1, one each for C and D; unlisted classes take one cycle
   always @* begin
      cycles_o = `IUVP_CYC_1;
      case (VARIANT)
         `IUVP_VAR_A, `IUVP_VAR_B0, `IUVP_VAR_B1: begin
            case (cls_i)
               `IUVP_CLS_LD_SINGLE, `IUVP_CLS_TRAP_TAKEN,
               `IUVP_CLS_JUMP_LINK, `IUVP_CLS_RET_TRAP:
                  cycles_o = `IUVP_CYC_2;
               `IUVP_CLS_BR_UNTAKEN:
                  cycles_o = (VARIANT == `IUVP_VAR_A) ? `IUVP_CYC_2 : `IUVP_CYC_1;
               `IUVP_CLS_LD_DOUBLE, `IUVP_CLS_ST_SINGLE, `IUVP_CLS_TRAP_UNTAKEN:
                  cycles_o = `IUVP_CYC_3;
               `IUVP_CLS_ST_DOUBLE, `IUVP_CLS_ATOMIC_LDST, `IUVP_CLS_SWAP:
                  cycles_o = `IUVP_CYC_4;
               default:
                  cycles_o = `IUVP_CYC_1;
            endcase
         end
         `IUVP_VAR_C: begin
            case (cls_i)
               `IUVP_CLS_LD_DOUBLE, `IUVP_CLS_ST_SINGLE,
               `IUVP_CLS_JUMP_LINK, `IUVP_CLS_RET_TRAP:
                  cycles_o = `IUVP_CYC_2;
               `IUVP_CLS_ST_DOUBLE:
                  cycles_o = `IUVP_CYC_3;
               `IUVP_CLS_TRAP_TAKEN:
                  cycles_o = `IUVP_CYC_5;
               default:
                  cycles_o = `IUVP_CYC_1;
            endcase
         end
         `IUVP_VAR_D: begin
            case (cls_i)
               `IUVP_CLS_ST_SINGLE, `IUVP_CLS_ST_DOUBLE:
                  cycles_o = reg_reg_addr_i ? `IUVP_CYC_2 : `IUVP_CYC_1;
               `IUVP_CLS_RET_TRAP, `IUVP_CLS_STORE_FQ, `IUVP_CLS_TRAP_TAKEN:
                  cycles_o = `IUVP_CYC_2;
               `IUVP_CLS_UNSIGNED_MULTIPLY, `IUVP_CLS_UNSIGNED_MULTIPLY_FLAGS,
               `IUVP_CLS_SIGNED_MULTIPLY, `IUVP_CLS_SIGNED_MULTIPLY_FLAGS:
                  cycles_o = `IUVP_CYC_5;
               default:
                  cycles_o = `IUVP_CYC_1;
            endcase
         end
         default:
            cycles_o = `IUVP_CYC_1;
      endcase
   end
endmodule

//--- rtl/iuvp_trap_prio.v
// trap filter and priority encoder per variant
`include "iuvp_map.vh"
module iuvp_trap_prio #(
   parameter [2:0] VARIANT = `IUVP_VAR_A
) (
   input  wire [`IUVP_TRQ_W-1:0] req_i,
   output reg                    take_o,
   output reg  [7:0]             tt_o
);
   wire is_c = (VARIANT == `IUVP_VAR_C);
   wire is_d = (VARIANT == `IUVP_VAR_D);
   reg  [`IUVP_TRQ_W-1:0] en;
   // mask off traps the variant does not have
   always @* begin
      en = req_i;
      en[`IUVP_TRQ_INSTR_ERR] = req_i[`IUVP_TRQ_INSTR_ERR] & is_c;
      en[`IUVP_TRQ_REG_ERR]   = req_i[`IUVP_TRQ_REG_ERR] & is_c;
      en[`IUVP_TRQ_DATA_ERR]  = req_i[`IUVP_TRQ_DATA_ERR] & is_c;
      en[`IUVP_TRQ_INSTR_MISS] = req_i[`IUVP_TRQ_INSTR_MISS] & is_d;
      en[`IUVP_TRQ_DATA_MISS]  = req_i[`IUVP_TRQ_DATA_MISS] & is_d;
      en[`IUVP_TRQ_WATCHPOINT] = req_i[`IUVP_TRQ_WATCHPOINT] & is_d;
   end
   // fixed priority; error mode first, watchpoint last
   always @* begin
      take_o = 1'b1;
      tt_o   = `IUVP_RST_TT;
      if (en[`IUVP_TRQ_ERROR_MODE]) begin
         tt_o = is_d ? `IUVP_TT_ERROR_RESET : `IUVP_TT_RESET;
      end else if (en[`IUVP_TRQ_INSTR_MISS]) begin
         tt_o = `IUVP_TT_INSTR_MISS;
      end else if (en[`IUVP_TRQ_INSTR_ERR]) begin
         tt_o = `IUVP_TT_INSTR_ERR;
      end else if ((VARIANT == `IUVP_VAR_A) && en[`IUVP_TRQ_ILLEGAL]) begin
         tt_o = `IUVP_TT_ILLEGAL;
      end else if (en[`IUVP_TRQ_PRIVILEGED]) begin
         tt_o = `IUVP_TT_PRIVILEGED;
      end else if (en[`IUVP_TRQ_ILLEGAL]) begin
         tt_o = `IUVP_TT_ILLEGAL;
      end else if (en[`IUVP_TRQ_REG_ERR]) begin
         tt_o = `IUVP_TT_REG_ERR;
      end else if (en[`IUVP_TRQ_DATA_ERR]) begin
         tt_o = `IUVP_TT_DATA_ERR;
      end else if (en[`IUVP_TRQ_DATA_MISS]) begin
         tt_o = `IUVP_TT_DATA_MISS;
      end else if (en[`IUVP_TRQ_WATCHPOINT]) begin
         tt_o = `IUVP_TT_WATCHPOINT;
      end else begin
         take_o = 1'b0;
      end
   end
endmodule

//--- rtl/iuvp_profile.v
// integer-unit variant profile: traps, memory widths, windows, timing
//
// How it works
// - parity error traps only in variant C
// - no divide, store-error, flush, 0x60-0x7F traps
// - variant A swaps privileged/illegal priority
// - miss and watchpoint traps only variant D
// - variant D error mode resets with 0x20
// - store barrier acts as Y read, rd=0
// - ancillary write acts as Y write
// - B1 drives ADDRESS_SPACE_IDENTIFIER[2:0] and 24 address bits
// - variant D drives ADDRESS_SPACE_IDENTIFIER[6:0] only
// - others drive 32 address, 8 ADDRESS_SPACE_IDENTIFIER bits
// - A and C seven windows, others eight
// - zero-wait memory, default one cycle
// - variant A two-cycle instruction classes
// - B variants untaken branch one cycle
// - A/B three- and four-cycle classes
// - variant C cycle table
// - variant D register-register stores and returns two cycles
// - variant D multiplies take five cycles
// - default trap model only
`include "iuvp_map.vh"
module iuvp_profile #(
   parameter [2:0] VARIANT = `IUVP_VAR_A
) (
   input  wire        sys_clk_i,
   input  wire        rst_i,
   // instruction issue
   input  wire        issue_valid_i,
   input  wire [4:0]  issue_class_i,
   input  wire        issue_reg_reg_addr_i,
   input  wire [4:0]  issue_rd_i,
   // trap requests from the pipeline
   input  wire        error_mode_i,
   input  wire        ext_reset_req_i,
   input  wire        instr_miss_i,
   input  wire        instr_parity_err_i,
   input  wire        privileged_viol_i,
   input  wire        illegal_instr_i,
   input  wire        reg_parity_err_i,
   input  wire        data_parity_err_i,
   input  wire        data_miss_i,
   input  wire        watchpoint_hit_i,
   input  wire        divide_zero_i,
   input  wire        data_store_err_i,
   input  wire        flush_unimpl_i,
   input  wire        impl_dep_exc_i,
   // memory request
   input  wire        mem_req_i,
   input  wire [31:0] mem_addr_i,
   input  wire [7:0]  mem_asi_i,
   // outputs
   output reg         busy_o,
   output reg         done_o,
   output reg  [2:0]  cycles_o,
   output reg         y_read_o,
   output reg         y_write_o,
   output reg  [4:0]  eff_rd_o,
   output reg         trap_o,
   output reg  [7:0]  trap_type_code_o,
   output reg         mem_req_o,
   output reg  [31:0] mem_addr_o,
   output reg  [7:0]  address_space_identifier_o,
   output reg  [3:0]  num_windows_o,
   output reg         enhanced_trap_model_o
);
   localparam ST_IDLE = 1'b0;
   localparam ST_BUSY = 1'b1;

   function [31:0] addr_mask;
      input [2:0] v;
      begin
         addr_mask = (v == `IUVP_VAR_B1) ? `IUVP_ADDR_MASK_B1 : `IUVP_ADDR_MASK_FULL;
      end
   endfunction

   function [7:0] asi_mask;
      input [2:0] v;
      begin
         case (v)
            `IUVP_VAR_B1: asi_mask = `IUVP_ASI_MASK_B1;
            `IUVP_VAR_D:  asi_mask = `IUVP_ASI_MASK_D;
            default:      asi_mask = `IUVP_ASI_MASK_FULL;
         endcase
      end
   endfunction

   function [3:0] win_count;
      input [2:0] v;
      begin
         case (v)
            `IUVP_VAR_A, `IUVP_VAR_C: win_count = `IUVP_WIN_SEVEN;
            default:                  win_count = `IUVP_WIN_EIGHT;
         endcase
      end
   endfunction

   reg        state_r;
   reg        state_nxt;
   reg [2:0]  cnt_r;
   reg [2:0]  cnt_nxt;
   wire [2:0] table_cycles;
   wire       prio_take;
   wire [7:0] prio_tt;
   wire [`IUVP_TRQ_W-1:0] trq;

   // cycle lookup for the issued class
   iuvp_cycle_table #(
      .VARIANT (VARIANT)
   ) u_cycles (
      .cls_i          (issue_class_i),
      .reg_reg_addr_i (issue_reg_reg_addr_i),
      .cycles_o       (table_cycles)
   );

   // divide, store-error, flush and implementation traps never reach the encoder
   assign trq[`IUVP_TRQ_ERROR_MODE] = error_mode_i;
   assign trq[`IUVP_TRQ_INSTR_MISS] = instr_miss_i;
   assign trq[`IUVP_TRQ_INSTR_ERR]  = instr_parity_err_i;
   assign trq[`IUVP_TRQ_PRIVILEGED] = privileged_viol_i;
   assign trq[`IUVP_TRQ_ILLEGAL]    = illegal_instr_i;
   assign trq[`IUVP_TRQ_REG_ERR]    = reg_parity_err_i;
   assign trq[`IUVP_TRQ_DATA_ERR]   = data_parity_err_i;
   assign trq[`IUVP_TRQ_DATA_MISS]  = data_miss_i;
   assign trq[`IUVP_TRQ_WATCHPOINT] = watchpoint_hit_i;

   // ignored sources, kept only in a dead term
   wire unused_traps = divide_zero_i | data_store_err_i | flush_unimpl_i | impl_dep_exc_i;

   iuvp_trap_prio #(
      .VARIANT (VARIANT)
   ) u_prio (
      .req_i  (trq),
      .take_o (prio_take),
      .tt_o   (prio_tt)
   );

   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (issue_valid_i && (table_cycles > `IUVP_CYC_1)) begin
               state_nxt = ST_BUSY;
               cnt_nxt   = table_cycles - `IUVP_CYC_1;
            end
         end
         ST_BUSY: begin
            cnt_nxt = cnt_r - `IUVP_CYC_1;
            if (cnt_r == `IUVP_CYC_1) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt   = `IUVP_RST_CNT;
         end
      endcase
   end

   // sequencer registers
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= `IUVP_RST_CNT;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // completion and busy outputs
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         cycles_o <= `IUVP_RST_CNT;
      end else begin
         busy_o <= (state_nxt == ST_BUSY);
         done_o <= ((state_r == ST_IDLE) && issue_valid_i && (table_cycles == `IUVP_CYC_1))
                   || ((state_r == ST_BUSY) && (cnt_r == `IUVP_CYC_1));
         if ((state_r == ST_IDLE) && issue_valid_i) begin
            cycles_o <= table_cycles;
         end
      end
   end

   // special register instruction aliasing
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         y_read_o  <= 1'b0;
         y_write_o <= 1'b0;
         eff_rd_o  <= 5'h00;
      end else begin
         y_read_o  <= 1'b0;
         y_write_o <= 1'b0;
         eff_rd_o  <= issue_rd_i;
         if ((state_r == ST_IDLE) && issue_valid_i) begin
            case (issue_class_i)
               `IUVP_CLS_STORE_BAR: begin
                  y_read_o <= 1'b1;
                  eff_rd_o <= 5'h00;
               end
               `IUVP_CLS_READ_Y: begin
                  y_read_o <= 1'b1;
               end
               `IUVP_CLS_WRITE_ANC, `IUVP_CLS_WRITE_Y: begin
                  // ancillary write goes to Y, rd dropped
                  y_write_o <= 1'b1;
                  eff_rd_o  <= 5'h00;
               end
               default: y_read_o <= 1'b0;
            endcase
         end
      end
   end

   // trap outputs; external reset always reports code zero
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trap_o           <= 1'b0;
         trap_type_code_o <= `IUVP_RST_TT;
      end else if (ext_reset_req_i) begin
         // only the external reset gives zero on D
         trap_o           <= 1'b1;
         trap_type_code_o <= `IUVP_TT_RESET;
      end else begin
         trap_o <= prio_take;
         if (prio_take) begin
            trap_type_code_o <= prio_tt;
         end
      end
   end

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_req_o                  <= 1'b0;
         mem_addr_o                 <= 32'h00000000;
         address_space_identifier_o <= 8'h00;
      end else begin
         mem_req_o                  <= mem_req_i;
         mem_addr_o                 <= mem_addr_i & addr_mask(VARIANT);
         address_space_identifier_o <= mem_asi_i & asi_mask(VARIANT);
      end
   end

   // static profile outputs, flop-driven
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         num_windows_o         <= 4'h0;
         enhanced_trap_model_o <= 1'b0;
      end else begin
         num_windows_o         <= win_count(VARIANT);
         enhanced_trap_model_o <= 1'b0 & unused_traps;
      end
   end
endmodule

//--- testbench/iuvp_profile_props.sv
// assertion checker for the integer-unit variant profile
`include "iuvp_map.vh"
module iuvp_profile_props #(
   parameter [2:0] VARIANT = `IUVP_VAR_A
) (
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        issue_valid_i,
   input wire logic [4:0]  issue_class_i,
   input wire logic        error_mode_i,
   input wire logic        ext_reset_req_i,
   input wire logic        instr_miss_i,
   input wire logic        instr_parity_err_i,
   input wire logic        privileged_viol_i,
   input wire logic        illegal_instr_i,
   input wire logic        mem_req_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic [7:0]  mem_asi_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic [2:0]  cycles_o,
   input wire logic        y_read_o,
   input wire logic        y_write_o,
   input wire logic [4:0]  eff_rd_o,
   input wire logic        trap_o,
   input wire logic [7:0]  trap_type_code_o,
   input wire logic        mem_req_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic [7:0]  address_space_identifier_o,
   input wire logic [3:0]  num_windows_o,
   input wire logic        enhanced_trap_model_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // per-variant masks and window count
   localparam logic [31:0] AMASK = (VARIANT == `IUVP_VAR_B1) ? `IUVP_ADDR_MASK_B1
                                                              : `IUVP_ADDR_MASK_FULL;
   localparam logic [7:0]  SMASK = (VARIANT == `IUVP_VAR_B1) ? `IUVP_ASI_MASK_B1 :
                                   (VARIANT == `IUVP_VAR_D) ? `IUVP_ASI_MASK_D : `IUVP_ASI_MASK_FULL;
   localparam logic [3:0]  WINS  = (VARIANT == `IUVP_VAR_A || VARIANT == `IUVP_VAR_C)
                                   ? `IUVP_WIN_SEVEN : `IUVP_WIN_EIGHT;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // an issue that the block accepts
   sequence s_take(cond);
      issue_valid_i && !busy_o && cond;
   endsequence
   a_enh_model_off: assert property (enhanced_trap_model_o == 1'b0)
      else $error("enhanced trap model flag set");
   a_window_count: assert property (!$past(rst_i) |-> num_windows_o == WINS)
      else $error("window count wrong");
   a_asi_masked: assert property (mem_req_i |=> mem_req_o &&
      address_space_identifier_o == ($past(mem_asi_i) & SMASK)) else $error("asi not masked");
   a_addr_masked: assert property (mem_req_i |=>
      mem_addr_o == ($past(mem_addr_i) & AMASK)) else $error("address not masked");
   a_error_code: assert property (error_mode_i && !ext_reset_req_i |=> trap_o &&
      trap_type_code_o == ((VARIANT == `IUVP_VAR_D) ? `IUVP_TT_ERROR_RESET : `IUVP_TT_RESET))
      else $error("error state code wrong");
   a_priv_illegal_order: assert property (privileged_viol_i && illegal_instr_i &&
      !error_mode_i && !ext_reset_req_i && !instr_miss_i && !instr_parity_err_i |=>
      trap_type_code_o == ((VARIANT == `IUVP_VAR_A) ? `IUVP_TT_ILLEGAL : `IUVP_TT_PRIVILEGED))
      else $error("privileged and illegal order wrong");
   a_variant_codes: assert property (trap_o |->
      (VARIANT == `IUVP_VAR_D || !(trap_type_code_o inside {8'h3C, 8'h2C, 8'h0B})) &&
      (VARIANT == `IUVP_VAR_C || !(trap_type_code_o inside {8'h21, 8'h29})))
      else $error("trap code from another variant");
   a_mult_five: assert property (s_take(VARIANT == `IUVP_VAR_D &&
      issue_class_i >= `IUVP_CLS_UNSIGNED_MULTIPLY && issue_class_i <= `IUVP_CLS_SIGNED_MULTIPLY_FLAGS)
      |-> ##4 !done_o ##1 (done_o && cycles_o == 3'h5)) else $error("multiply time wrong");
   a_branch_untaken: assert property (s_take(issue_class_i == `IUVP_CLS_BR_UNTAKEN) |->
      if (VARIANT == `IUVP_VAR_A) (##1 !done_o ##1 done_o) else (##1 done_o))
      else $error("untaken branch time wrong");
   a_trap_taken_time: assert property (s_take(issue_class_i == `IUVP_CLS_TRAP_TAKEN) |->
      if (VARIANT == `IUVP_VAR_C) (##4 !done_o ##1 done_o) else (##1 !done_o ##1 done_o))
      else $error("taken trap time wrong");
   a_barrier_rd_zero: assert property (s_take(issue_class_i == `IUVP_CLS_STORE_BAR) |->
      ##1 (done_o && y_read_o && !y_write_o && eff_rd_o == 5'h00)) else $error("barrier wrong");
   a_anc_as_y_write: assert property (s_take(issue_class_i == `IUVP_CLS_WRITE_ANC) |->
      ##1 (done_o && y_write_o && !y_read_o && eff_rd_o == 5'h00)) else $error("anc write wrong");
endmodule

bind iuvp_profile iuvp_profile_props #(.VARIANT(VARIANT)) u_props (
   .sys_clk_i, .rst_i, .issue_valid_i, .issue_class_i, .error_mode_i, .ext_reset_req_i,
   .instr_miss_i, .instr_parity_err_i, .privileged_viol_i, .illegal_instr_i, .mem_req_i,
   .mem_addr_i, .mem_asi_i, .busy_o, .done_o, .cycles_o, .y_read_o, .y_write_o, .eff_rd_o,
   .trap_o, .trap_type_code_o, .mem_req_o, .mem_addr_o, .address_space_identifier_o,
   .num_windows_o, .enhanced_trap_model_o
);

//--- testbench/iuvp_mem_sink.sv
// zero-wait memory model that records each request it sees
module iuvp_mem_sink (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [7:0]  asi_i,
   output logic      [31:0] addr_o,
   output logic      [7:0]  asi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_i) begin
      if (req_i) begin
         addr_o <= addr_i;
         asi_o  <= asi_i;
      end
   end
endmodule

//--- testbench/tb_iuvp_profile.sv
// bench: five variants side by side against a model
`include "iuvp_map.vh"
module tb_iuvp_profile;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic req; logic [31:0] addr; logic [7:0] address_space_identifier; logic [13:0] trq;} iuvp_step_t;
   logic        sys_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        issue_valid_i = 1'b0;
   logic [4:0]  issue_class_i = 5'h00;
   logic        issue_reg_reg_addr_i = 1'b0;
   logic [4:0]  issue_rd_i = 5'h00;
   logic [13:0] trq = 14'h0000;
   logic        mem_req_i = 1'b0;
   logic [31:0] mem_addr_i = 32'h00000000;
   logic [7:0]  mem_asi_i = 8'h00;
   logic [31:0] seed = 32'h0000B562;
   int          failures = 0;
   int          cmp_count = 0;
   int          tick_count = 0;
   logic [7:0]  last_tt [5];
   iuvp_step_t  hist [$];
   wire         busy [5], done [5], yrd [5], ywr [5], trap_f [5], enh [5], mreq [5];
   wire [2:0]   cyc [5];
   wire [4:0]   erd [5];
   wire [7:0]   tcode [5], masi [5], sink_asi [5];
   wire [31:0]  maddr [5], sink_addr [5];
   wire [3:0]   wins [5];

   always #20 sys_clk_i = ~sys_clk_i;

   // one design and one memory model per variant
   for (genvar g = 0; g < 5; g++) begin : g_var
      iuvp_profile #(.VARIANT(3'(g))) uut (
         .sys_clk_i, .rst_i, .issue_valid_i, .issue_class_i, .issue_reg_reg_addr_i, .issue_rd_i,
         .ext_reset_req_i(trq[0]), .error_mode_i(trq[1]), .instr_miss_i(trq[2]),
         .instr_parity_err_i(trq[3]), .privileged_viol_i(trq[4]), .illegal_instr_i(trq[5]),
         .reg_parity_err_i(trq[6]), .data_parity_err_i(trq[7]), .data_miss_i(trq[8]),
         .watchpoint_hit_i(trq[9]), .divide_zero_i(trq[10]), .data_store_err_i(trq[11]),
         .flush_unimpl_i(trq[12]), .impl_dep_exc_i(trq[13]), .mem_req_i, .mem_addr_i, .mem_asi_i,
         .busy_o(busy[g]), .done_o(done[g]), .cycles_o(cyc[g]), .y_read_o(yrd[g]),
         .y_write_o(ywr[g]), .eff_rd_o(erd[g]), .trap_o(trap_f[g]), .trap_type_code_o(tcode[g]),
         .mem_req_o(mreq[g]), .mem_addr_o(maddr[g]), .address_space_identifier_o(masi[g]),
         .num_windows_o(wins[g]), .enhanced_trap_model_o(enh[g]));
      iuvp_mem_sink sink (.clk_i(sys_clk_i), .req_i(mreq[g]), .addr_i(maddr[g]),
         .asi_i(masi[g]), .addr_o(sink_addr[g]), .asi_o(sink_asi[g]));
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected cycle count, zero-wait memory
   function automatic int exp_cyc(int v, logic [4:0] c, logic rr);
      if (v == 4) begin
         if (rr && (c == `IUVP_CLS_ST_SINGLE || c == `IUVP_CLS_ST_DOUBLE)) return 2;
         if (c inside {`IUVP_CLS_RET_TRAP, `IUVP_CLS_STORE_FQ, `IUVP_CLS_TRAP_TAKEN}) return 2;
         if (c >= `IUVP_CLS_UNSIGNED_MULTIPLY && c <= `IUVP_CLS_SIGNED_MULTIPLY_FLAGS) return 5;
         return 1;
      end
      if (v == 3) begin
         case (c)
            `IUVP_CLS_LD_DOUBLE, `IUVP_CLS_ST_SINGLE,
            `IUVP_CLS_JUMP_LINK, `IUVP_CLS_RET_TRAP: return 2;
            `IUVP_CLS_ST_DOUBLE: return 3;
            `IUVP_CLS_TRAP_TAKEN: return 5;
            default: return 1;
         endcase
      end
      case (c)
         `IUVP_CLS_LD_SINGLE, `IUVP_CLS_TRAP_TAKEN,
         `IUVP_CLS_JUMP_LINK, `IUVP_CLS_RET_TRAP: return 2;
         `IUVP_CLS_BR_UNTAKEN: return (v == 0) ? 2 : 1;
         `IUVP_CLS_LD_DOUBLE, `IUVP_CLS_ST_SINGLE, `IUVP_CLS_TRAP_UNTAKEN: return 3;
         `IUVP_CLS_ST_DOUBLE, `IUVP_CLS_ATOMIC_LDST, `IUVP_CLS_SWAP: return 4;
         default: return 1;
      endcase
   endfunction

   // expected trap flag and code
   function automatic logic [8:0] exp_trap(int v, logic [13:0] r);
      if (r[0]) return {1'b1, `IUVP_TT_RESET};
      // error state code on variant D
      if (r[1]) return {1'b1, (v == 4) ? `IUVP_TT_ERROR_RESET : `IUVP_TT_RESET};
      if (r[2] && v == 4) return {1'b1, `IUVP_TT_INSTR_MISS};
      if (r[3] && v == 3) return {1'b1, `IUVP_TT_INSTR_ERR};
      if (r[4] && r[5]) return {1'b1, (v == 0) ? `IUVP_TT_ILLEGAL : `IUVP_TT_PRIVILEGED};
      if (r[4]) return {1'b1, `IUVP_TT_PRIVILEGED};
      if (r[5]) return {1'b1, `IUVP_TT_ILLEGAL};
      if (r[6] && v == 3) return {1'b1, `IUVP_TT_REG_ERR};
      if (r[7] && v == 3) return {1'b1, `IUVP_TT_DATA_ERR};
      if (r[8] && v == 4) return {1'b1, `IUVP_TT_DATA_MISS};
      if (r[9] && v == 4) return {1'b1, `IUVP_TT_WATCHPOINT};
      return 9'h000;
   endfunction

   task automatic check(logic ok, string msg);
      cmp_count++;
      if (!ok) begin
         failures++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic final_report();
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // reset, then windows and trap model
   task automatic restart();
      @(posedge sys_clk_i);
      rst_i     <= 1'b1;
      trq       <= 14'h0000;
      mem_req_i <= 1'b0;
      @(negedge sys_clk_i);
      for (int v = 0; v < 5; v++) check(trap_f[v] === 1'b0 && wins[v] === 4'h0, "reset state");
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      hist = {iuvp_step_t'(0), iuvp_step_t'(0)};
      last_tt = '{default: `IUVP_RST_TT};
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      for (int v = 0; v < 5; v++) begin
         check(wins[v] === ((v == 0 || v == 3) ? 4'h7 : 4'h8), "window count");
         check(enh[v] === 1'b0, "trap model flag");
      end
   endtask

   // one issue, then done, count, Y access and rd per variant
   task automatic issue(logic [4:0] c, logic rr, logic [4:0] rd);
      int   n;
      logic zr;
      @(posedge sys_clk_i);
      issue_valid_i        <= 1'b1;
      issue_class_i        <= c;
      issue_reg_reg_addr_i <= rr;
      issue_rd_i           <= rd;
      @(posedge sys_clk_i);
      issue_valid_i <= 1'b0;
      zr = (c == `IUVP_CLS_STORE_BAR || c == `IUVP_CLS_WRITE_ANC || c == `IUVP_CLS_WRITE_Y);
      for (int k = 1; k < 7; k++) begin
         @(negedge sys_clk_i);
         for (int v = 0; v < 5; v++) begin
            n = exp_cyc(v, c, rr);
            check(done[v] === (k == n), "done timing");
            if (k == n) begin
               check(busy[v] === 1'b0 && cyc[v] === 3'(n), "cycle count");
               check(yrd[v] === (c == `IUVP_CLS_STORE_BAR || c == `IUVP_CLS_READ_Y), "y read");
               check(ywr[v] === (zr && c != `IUVP_CLS_STORE_BAR), "y write");
               check(erd[v] === (zr ? 5'h00 : rd), "dest field");
            end
         end
      end
   endtask

   // random trap and memory requests, one per cycle
   task automatic traffic(int cnt);
      iuvp_step_t st;
      logic [8:0] x;
      for (int i = 0; i < cnt; i++) begin
         @(posedge sys_clk_i);
         st.trq     = 14'(rnd() & rnd() & rnd());
         st.req     = 1'(rnd());
         st.addr    = rnd();
         st.address_space_identifier     = 8'(rnd());
         {mem_req_i, mem_addr_i, mem_asi_i, trq} <= st;
         hist.push_back(st);
         @(negedge sys_clk_i);
         for (int v = 0; v < 5; v++) begin
            x = exp_trap(v, hist[$-1].trq);
            if (x[8]) last_tt[v] = x[7:0];
            check(trap_f[v] === x[8], "trap flag");
            check(tcode[v] === last_tt[v], "trap code");
            check(mreq[v] === hist[$-1].req, "memory request");
            if (hist[$-2].req) begin
               check(sink_addr[v] === (hist[$-2].addr & ((v == 2) ? 32'h00FFFFFF
                  : 32'hFFFFFFFF)), "memory address");
               check(sink_asi[v] === (hist[$-2].address_space_identifier & ((v == 2) ? 8'h07 : (v == 4) ? 8'h7F
                  : 8'hFF)), "address space");
            end
         end
         void'(hist.pop_front());
      end
   endtask

   // hang guard, far above the run length
   always @(posedge sys_clk_i) begin
      tick_count <= tick_count + 1;
      if (tick_count == 8000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      restart();
      for (int c = 0; c < 44; c++) issue(5'(c / 2), 1'(c), 5'(rnd()));
      repeat (60) issue(5'(rnd() % 22), 1'(rnd()), 5'(rnd()));
      traffic(600);
      restart();
      traffic(100);
      final_report();
   end
endmodule
